// ### src/itsw_timer.sv
// programmable 8-bit interval timer with prescaler and square-wave output
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - compare, two prescalers, up counter, comparator, toggle
// - counter steps every 8 or 128 us
// - interval is compare value plus one ticks
// - load compare, then start clears and restarts
// - equality of counter and compare raises request
// - match clears counter, counting repeats
// - toggle flips each match, drives wave pin
// - unmasked timer request ends the halted state
// - mask bit set blocks timer interrupt
// - zero compare: one match, then output stays high
// - stall ends on reset, stop or start
// - start at zero drops output, high after interval
// - 3-bit control, accumulator bits 0-2, read/write
// - bits 0-1 gate output, bit 2 selects tick
// - reset: clear counters, compare FF, control set
module itsw_timer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [itsw_pkg::ACC_W-1:0] acc_wdata_i,
    input wire logic load_compare_op_i,
    input wire logic ctrl_write_i,
    input wire logic timer_start_op_i,
    input wire logic stop_mode_i,
    input wire logic halt_state_i,
    input wire logic timer_mask_bit_i,
    input wire logic irq_ack_i,
    output logic [itsw_pkg::ACC_W-1:0] ctrl_rdata_o,
    output logic [itsw_pkg::COMPARE_W-1:0] upcounter_o,
    output logic timer_match_irq_o,
    output logic timer_irq_take_o,
    output logic halt_release_o,
    output logic timer_match_o,
    output logic square_wave_out_o
);

    // register state
    logic [itsw_pkg::COMPARE_W-1:0] compare_q;
    logic [itsw_pkg::COMPARE_W-1:0] compare_d;
    logic [itsw_pkg::CTRL_W-1:0] ctrl_q;
    logic [itsw_pkg::CTRL_W-1:0] ctrl_d;

    // counting state
    logic [itsw_pkg::COMPARE_W-1:0] count_q;
    logic [itsw_pkg::COMPARE_W-1:0] count_d;
    logic toggle_q;
    logic toggle_d;
    logic stall_q;
    logic stall_d;
    logic match;

    // request and output state
    logic irq_q;
    logic irq_d;
    logic release_q;
    logic release_d;
    logic match_q;
    logic match_d;
    logic wave_q;
    logic wave_d;

    // prescaler chain
    logic restart;
    logic base_carry;
    logic first_carry;
    logic second_en;
    logic tick;
    logic tick_sel;
    logic wave_enabled;

    // start or stop mode re-initialises the whole counting path
    assign restart = timer_start_op_i || stop_mode_i;

    assign tick_sel = ctrl_q[itsw_pkg::CTRL_TICK_SEL_BIT];

    assign wave_enabled = ({ctrl_q[itsw_pkg::CTRL_OE_HI_BIT],
                            ctrl_q[itsw_pkg::CTRL_OE_LO_BIT]} == itsw_pkg::OE_PATTERN);

    // reference machine cycle from the 40 ns clock
    itsw_prescaler #(
        .W(itsw_pkg::BASE_W),
        .DIV(itsw_pkg::REF_DIV_CYCLES)
    ) u_base (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clr_i(restart),
        .en_i(1'b1),
        .carry_o(base_carry)
    );

    // first prescaler: divide by 16 for the coarse tick
    itsw_prescaler #(
        .W(itsw_pkg::FIRST_PRESC_W),
        .DIV(itsw_pkg::FIRST_PRESC_DIV)
    ) u_first (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clr_i(restart),
        .en_i(base_carry),
        .carry_o(first_carry)
    );

    // coarse tick passes through the first prescaler, fine tick bypasses it
    assign second_en = tick_sel ? first_carry : base_carry;

    // second prescaler: divide by 8, its carry is the counter tick
    itsw_prescaler #(
        .W(itsw_pkg::SECOND_PRESC_W),
        .DIV(itsw_pkg::SECOND_PRESC_DIV)
    ) u_second (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clr_i(restart),
        .en_i(second_en),
        .carry_o(tick)
    );

    // compare value and control register writes
    always_comb begin
        compare_d = compare_q;
        ctrl_d = ctrl_q;
        if (load_compare_op_i) begin
            compare_d = acc_wdata_i[itsw_pkg::COMPARE_W-1:0];
        end
        if (ctrl_write_i) begin
            ctrl_d = acc_wdata_i[itsw_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare_q <= itsw_pkg::COMPARE_RESET;
            ctrl_q <= itsw_pkg::CTRL_RESET;
        end else begin
            compare_q <= compare_d;
            ctrl_q <= ctrl_d;
        end
    end

    // up counter, comparator, toggle flip-flop and zero-value stall
    always_comb begin
        count_d = count_q;
        toggle_d = toggle_q;
        stall_d = stall_q;
        match = 1'b0;
        if (restart) begin
            count_d = itsw_pkg::COUNT_ZERO;
            toggle_d = 1'b0;
            stall_d = 1'b0;
        end else if (tick && !stall_q) begin
            if (count_q == compare_q) begin
                match = 1'b1;
                count_d = itsw_pkg::COUNT_ZERO;
                toggle_d = !toggle_q;
                if (compare_q == itsw_pkg::COUNT_ZERO) begin
                    stall_d = 1'b1;
                end
            end else begin
                count_d = count_q + itsw_pkg::COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count_q <= itsw_pkg::COUNT_ZERO;
            toggle_q <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            count_q <= count_d;
            toggle_q <= toggle_d;
            stall_q <= stall_d;
        end
    end

    // timer request flag; a match in the acknowledge cycle still sets it
    always_comb begin
        irq_d = irq_q;
        if (irq_ack_i || stop_mode_i) begin
            irq_d = 1'b0;
        end
        if (match) begin
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // halt release pulse, match strobe and wave output
    always_comb begin
        release_d = match && halt_state_i && !timer_mask_bit_i;
        match_d = match;
        wave_d = toggle_d && wave_enabled;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            release_q <= 1'b0;
            match_q <= 1'b0;
            wave_q <= 1'b0;
        end else begin
            release_q <= release_d;
            match_q <= match_d;
            wave_q <= wave_d;
        end
    end

    // readback and status
    assign ctrl_rdata_o = {{(itsw_pkg::ACC_W - itsw_pkg::CTRL_W){1'b0}}, ctrl_q};
    assign upcounter_o = count_q;
    assign timer_match_irq_o = irq_q;
    assign timer_irq_take_o = irq_q && !timer_mask_bit_i;
    assign halt_release_o = release_q;
    assign timer_match_o = match_q;
    assign square_wave_out_o = wave_q;

endmodule

`default_nettype wire

// ### src/itsw_pkg.sv
// constants shared by the interval timer with square-wave output
package itsw_pkg;

    // system clock of this design
    localparam int CLK_PERIOD_NS = 40;

    // one reference machine cycle, the base that the prescalers divide
    localparam int REF_CYCLE_NS = 1000;
    localparam int REF_DIV_CYCLES = (REF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BASE_W = 5;

    // tick periods as printed, in microseconds
    localparam int TICK_FINE_US = 8;
    localparam int TICK_COARSE_US = 128;
    localparam int NS_PER_US = 1000;
    localparam int TICK_FINE_CYCLES = TICK_FINE_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int TICK_COARSE_CYCLES = TICK_COARSE_US * NS_PER_US / CLK_PERIOD_NS;

    // prescaler division ratios derived from the tick periods
    localparam int SECOND_PRESC_DIV = TICK_FINE_US * NS_PER_US / REF_CYCLE_NS;
    localparam int FIRST_PRESC_DIV = TICK_COARSE_US / TICK_FINE_US;

    // widths
    localparam int COMPARE_W = 8;
    localparam int CTRL_W = 3;
    localparam int FIRST_PRESC_W = 4;
    localparam int SECOND_PRESC_W = 3;
    localparam int ACC_W = 8;

    // reset values
    localparam logic [COMPARE_W-1:0] COMPARE_RESET = 8'hFF;
    localparam logic [COMPARE_W-1:0] COUNT_ZERO = 8'h00;
    localparam logic [COMPARE_W-1:0] COUNT_ONE = 8'h01;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;

    // timer_control field positions
    localparam int CTRL_OE_LO_BIT = 0;
    localparam int CTRL_OE_HI_BIT = 1;
    localparam int CTRL_TICK_SEL_BIT = 2;

    // output_enable_hi/output_enable_lo pattern that lets the wave out
    localparam logic [1:0] OE_PATTERN = 2'h1;

endpackage

// ### src/itsw_prescaler.sv
// one modulo counter stage of the prescaler chain
`timescale 1ns/1ps
`default_nettype none

module itsw_prescaler #(
    parameter int W = 4,
    parameter int DIV = 16
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clr_i,
    input wire logic en_i,
    output logic carry_o
);

    localparam logic [W-1:0] LAST = W'(DIV - 1);
    localparam logic [W-1:0] ZERO = '0;
    localparam logic [W-1:0] STEP = W'(1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // carry marks the last count of the stage
    assign carry_o = en_i && !clr_i && (cnt_q == LAST);

    always_comb begin
        cnt_d = cnt_q;
        if (clr_i) begin
            cnt_d = ZERO;
        end else if (en_i) begin
            if (cnt_q == LAST) begin
                cnt_d = ZERO;
            end else begin
                cnt_d = cnt_q + STEP;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

`default_nettype wire

// ### verification/itsw_timer_asserts.sv
// port checker for the interval timer
`timescale 1ns/1ps
`default_nettype none
module itsw_timer_asserts (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic ctrl_write_i,
    input wire logic timer_start_op_i,
    input wire logic stop_mode_i,
    input wire logic timer_mask_bit_i,
    input wire logic [7:0] ctrl_rdata_o,
    input wire logic [7:0] upcounter_o,
    input wire logic timer_match_irq_o,
    input wire logic timer_irq_take_o,
    input wire logic halt_release_o,
    input wire logic timer_match_o,
    input wire logic square_wave_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_wr;
        ##1 ctrl_rdata_o == {5'h00, $past(acc_wdata_i[2:0])};
    endsequence
    sequence s_on;
        $past(ctrl_rdata_o[1:0]) == 2'h1 && $past(ctrl_rdata_o[1:0], 2) == 2'h1;
    endsequence
    chk_ctrl_readback: assert property (ctrl_write_i |-> s_wr)
        else $error("control readback wrong");
    chk_match_flag: assert property (timer_match_o |-> timer_match_irq_o)
        else $error("match without request flag");
    chk_match_single: assert property (timer_match_o |=> !timer_match_o)
        else $error("match pulse too long");
    chk_match_clear: assert property (timer_match_o |-> upcounter_o == 8'h00)
        else $error("counter not cleared on match");
    chk_mask_take: assert property (1 |-> timer_irq_take_o == (timer_match_irq_o && !timer_mask_bit_i))
        else $error("masking wrong");
    chk_halt_cause: assert property (halt_release_o |-> timer_match_irq_o)
        else $error("halt release without request");
    chk_start_clear: assert property (timer_start_op_i |=> upcounter_o == 8'h00)
        else $error("start did not clear counter");
    chk_count_step: assert property (upcounter_o != $past(upcounter_o)
        |-> upcounter_o == $past(upcounter_o) + 8'h01 || upcounter_o == 8'h00)
        else $error("counter jumped");
    chk_gate_low: assert property (ctrl_rdata_o[1:0] != 2'h1
        && $past(ctrl_rdata_o[1:0]) != 2'h1 |-> !square_wave_out_o)
        else $error("wave not held low");
    chk_wave_toggle: assert property ((timer_match_o and s_on)
        |-> square_wave_out_o != $past(square_wave_out_o))
        else $error("wave did not toggle");
    chk_stop_clear: assert property (stop_mode_i |=> !timer_match_irq_o && upcounter_o == 8'h00)
        else $error("stop did not clear");
    chk_reset_vals: assert property (disable iff (1'b0) sys_rst_i
        |=> ctrl_rdata_o == 8'h07 && upcounter_o == 8'h00 && !square_wave_out_o)
        else $error("reset values wrong");
    chk_release_mask: assert property (halt_release_o |-> !$past(timer_mask_bit_i))
        else $error("halt released while masked");
endmodule
bind itsw_timer itsw_timer_asserts u_chk (.clk_i, .sys_rst_i, .acc_wdata_i, .ctrl_write_i,
    .timer_start_op_i, .stop_mode_i, .timer_mask_bit_i, .ctrl_rdata_o, .upcounter_o,
    .timer_match_irq_o, .timer_irq_take_o, .halt_release_o, .timer_match_o, .square_wave_out_o);
`default_nettype wire

// ### verification/itsw_timer_tb.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
module itsw_timer_tb;
    logic clk = 0, rst = 1, ld = 0, cw = 0, st = 0, stp = 0, hlt = 0, msk = 0, ack = 0;
    logic [7:0] d = 8'h00, rd, cnt, v;
    logic irq, take, hrel, m, w;
    logic [31:0] seed = 32'h080AF8F3;
    int errors = 0, cmp_count = 0, n, k, h;
    itsw_timer u_dut (.clk_i(clk), .sys_rst_i(rst), .acc_wdata_i(d), .load_compare_op_i(ld),
        .ctrl_write_i(cw), .timer_start_op_i(st), .stop_mode_i(stp), .halt_state_i(hlt),
        .timer_mask_bit_i(msk), .irq_ack_i(ack), .ctrl_rdata_o(rd), .upcounter_o(cnt),
        .timer_match_irq_o(irq), .timer_irq_take_o(take), .halt_release_o(hrel),
        .timer_match_o(m), .square_wave_out_o(w));
    initial begin
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic int span(input logic [7:0] c, input logic t);
        return (c + 1) * (t ? itsw_pkg::TICK_COARSE_CYCLES : itsw_pkg::TICK_FINE_CYCLES);
    endfunction
    task automatic cyc(input int c);
        repeat (c) begin
            @(posedge clk);
            #1;
            if (hrel === 1'b1) h++;
        end
    endtask
    task automatic op(input int kind, input logic [7:0] x);
        d = x;
        ld = kind == 0;
        cw = kind == 1;
        st = kind == 2;
        cyc(1);
        {ld, cw, st} = 3'h0;
        cyc(1);
    endtask
    task automatic wm(input int lim);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (m !== 1'b1 && n < lim);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #800000;
        errors++;
        complete_run;
    end
    initial begin
        cyc(8);
        rst = 0;
        chk(rd, 8'h07);
        chk({cnt, w, irq}, 10'h000);
        repeat (4) begin
            seed = lfsr(seed);
            op(1, seed[7:0]);
            chk(rd, {5'h00, seed[2:0]});
        end
        op(1, 8'h01);
        for (k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            v = {6'h00, seed[1:0]} + 8'h01;
            msk = seed[2];
            hlt = seed[3];
            h = 0;
            op(0, v);
            op(2, 8'h00);
            wm(5000);
            chk(n, span(v, 0) - 1);
            chk({irq, w, take}, {2'h3, !msk});
            wm(5000);
            chk(n, span(v, 0));
            chk(w, 0);
            ack = 1;
            cyc(2);
            ack = 0;
            chk(irq, 0);
            chk(h, (hlt && !msk) ? 2 : 0);
        end
        op(0, 8'h00);
        op(2, 8'h00);
        wm(300);
        chk(n, span(0, 0) - 1);
        chk(w, 1);
        wm(600);
        chk(n, 600);
        chk({cnt, m, w}, 10'h001);
        op(2, 8'h00);
        chk(w, 0);
        wm(300);
        chk(n, span(0, 0) - 1);
        chk(w, 1);
        stp = 1;
        cyc(3);
        chk({irq, cnt}, 9'h000);
        stp = 0;
        wm(300);
        chk(n, span(0, 0));
        chk(m, 1);
        op(1, 8'h03);
        op(2, 8'h00);
        wm(300);
        chk({m, w}, 2'h2);
        op(1, 8'h05);
        op(2, 8'h00);
        wm(5000);
        chk(n, span(0, 1) - 1);
        chk(w, 1);
        rst = 1;
        cyc(2);
        rst = 0;
        chk({rd, w}, 9'h00E);
        chk({cnt, irq}, 9'h000);
        complete_run;
    end
endmodule
`default_nettype wire
